// *** hdl/tmc_pkg.sv ***
// constants shared by the eight-bit timer/counter and its prescaler
// assumes a single 200 MHz clock; one clock cycle is one instruction cycle
package tmc_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0]  TMC_IDX_COUNT  = 10'h001;
    localparam logic [9:0]  TMC_IDX_ICTRL  = 10'h00b;
    localparam logic [9:0]  TMC_IDX_OPTION = 10'h081;
    localparam logic [11:0] TMC_ADDR_COUNT  = {TMC_IDX_COUNT, 2'b00};
    localparam logic [11:0] TMC_ADDR_ICTRL  = {TMC_IDX_ICTRL, 2'b00};
    localparam logic [11:0] TMC_ADDR_OPTION = {TMC_IDX_OPTION, 2'b00};
    // event status (ro), event clear (wo), event enable (rw)
    localparam logic [11:0] TMC_ADDR_EVSTAT = 12'h100;
    localparam logic [11:0] TMC_ADDR_EVCLR  = 12'h104;
    localparam logic [11:0] TMC_ADDR_EVEN   = 12'h108;

    // option_control fields
    localparam int TMC_OPT_CS   = 5;  // clock_source_select
    localparam int TMC_OPT_SE   = 4;  // source_edge_select
    localparam int TMC_OPT_PSA  = 3;  // prescaler_assign
    localparam int TMC_OPT_RMSB = 2;  // prescale_rate_msb, rate is [2:0]
    // interrupt_control fields
    localparam int TMC_ICR_IE   = 5;  // overflow_int_enable
    localparam int TMC_ICR_FLAG = 2;  // overflow_flag
    // event register bit of the overflow event
    localparam int TMC_EV_OVF   = 0;

    // values after reset
    localparam logic [7:0] TMC_RST_COUNT  = 8'h00;
    localparam logic [7:0] TMC_RST_ICTRL  = 8'h00;
    localparam logic [7:0] TMC_RST_OPTION = 8'hff;

    // cycles with no increment after a count write
    localparam logic [1:0] TMC_INHIBIT_CYC = 2'h2;

endpackage : tmc_pkg

// *** hdl/tmc_prescaler.sv ***
// shared eight-bit prescaler: divides a tick stream by two to the ratio
// assumes tick and clear come from logic on sys_clk
module tmc_prescaler (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       tick,
    input  wire logic       clear,
    input  wire logic [3:0] ratio_log,
    output logic            term
);
    import tmc_pkg::*;

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] mask;

    // bits below the ratio take part in the terminal count
    for (genvar i = 0; i < 8; i++) begin : g_mask
        assign mask[i] = (4'(i) < ratio_log);
    end

    // count is internal only; nothing outside can read or load it
    assign term  = tick & (&(cnt_q | ~mask));
    assign cnt_d = (clear | term) ? 8'h00 :
                   tick ? 8'(cnt_q + 8'h01) : cnt_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) cnt_q <= 8'h00;
        else         cnt_q <= cnt_d;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_clear_zeroes: assert property (clear |=> cnt_q == 8'h00)
        else $error("prescaler not cleared");
    a_term_spacing: assert property (
        (term && ratio_log == 4'h1) |=> (!term || ratio_log == 4'h0))
        else $error("prescaler terminal count too early");

endmodule // tmc_prescaler

// *** hdl/tmc_timer.sv ***
// eight-bit timer/counter with shared prescaler, behind an ahb-lite slave
// assumes one sys_clk cycle per instruction cycle; sleep_mode and
// wdt_clk_tick come from sys_clk logic, the counter pin is asynchronous
module tmc_timer (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        counter_clock_pin,
    input  wire logic        sleep_mode,
    input  wire logic        wdt_clk_tick,
    output logic             wdt_tick,
    output logic             irq
);
    import tmc_pkg::*;

    // bus slave state
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [11:0] addr_q;
    logic        ready_q;
    logic [31:0] rdata_q;

    // block state
    logic [7:0]  cnt_q;
    logic [7:0]  cnt_d;
    logic [1:0]  inh_q;
    logic [1:0]  inh_d;
    logic [7:0]  icr_q;
    logic [7:0]  icr_d;
    logic [7:0]  opt_q;
    logic        irq_q;
    logic        wdt_q;

    // pin synchroniser and edge history
    logic        pin_meta_q;
    logic        pin_sync_q;
    logic        pin_last_q;

    // address phase decode; only whole-word single transfers are expected
    // hsize is not looked at, so a narrow write still lands as a word
    logic        addr_ok;
    logic        rd_take;
    logic        wr_take;
    assign addr_ok = hsel & hready & htrans[1];
    assign rd_take = addr_ok & ~hwrite;
    assign wr_take = addr_ok & hwrite;

    // data phase write strobes
    logic        wr_cnt;
    logic        wr_icr;
    logic        wr_opt;
    logic        wr_evclr;
    logic        wr_even;
    assign wr_cnt   = wr_pend_q & (addr_q == TMC_ADDR_COUNT);
    assign wr_icr   = wr_pend_q & (addr_q == TMC_ADDR_ICTRL);
    assign wr_opt   = wr_pend_q & (addr_q == TMC_ADDR_OPTION);
    assign wr_evclr = wr_pend_q & (addr_q == TMC_ADDR_EVCLR);
    assign wr_even  = wr_pend_q & (addr_q == TMC_ADDR_EVEN);

    // read selection; unmapped addresses and the prescaler read zero
    logic [7:0]  rd_byte;
    assign rd_byte =
        (addr_q == TMC_ADDR_COUNT)  ? cnt_q :
        (addr_q == TMC_ADDR_ICTRL)  ? icr_q :
        (addr_q == TMC_ADDR_OPTION) ? opt_q :
        (addr_q == TMC_ADDR_EVSTAT) ? {7'h00, icr_q[TMC_ICR_FLAG]} :
        (addr_q == TMC_ADDR_EVEN)   ? {7'h00, icr_q[TMC_ICR_IE]} :
        8'h00;

    // option fields
    logic        sel_pin;
    logic        sel_fall;
    logic        psa_wdt;
    logic [2:0]  rate;
    assign sel_pin  = opt_q[TMC_OPT_CS];
    assign sel_fall = opt_q[TMC_OPT_SE];
    assign psa_wdt  = opt_q[TMC_OPT_PSA];
    assign rate     = opt_q[TMC_OPT_RMSB:0];

    // pin edges, taken only from synchronised copies
    logic        pin_rise;
    logic        pin_fall;
    logic        pin_edge;
    assign pin_rise = pin_sync_q & ~pin_last_q;
    assign pin_fall = ~pin_sync_q & pin_last_q;
    assign pin_edge = sel_fall ? pin_fall : pin_rise;

    // source tick: instruction cycle or pin edge, dead while asleep
    logic        src_tick;
    assign src_tick = (sel_pin ? pin_edge : 1'b1)
                      & ~sleep_mode;

    // prescaler sits on one path only; watchdog runs through sleep
    logic        pre_tick;
    logic        pre_term;
    logic [3:0]  pre_ratio;
    logic        pre_clear;
    assign pre_tick  = psa_wdt ? wdt_clk_tick : src_tick;
    // timer divides by two to rate plus one, watchdog by two to rate
    assign pre_ratio = psa_wdt ? {1'b0, rate} : 4'({1'b0, rate} + 4'h1);
    assign pre_clear = wr_cnt & ~psa_wdt;

    tmc_prescaler u_prescaler (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .tick      (pre_tick),
        .clear     (pre_clear),
        .ratio_log (pre_ratio),
        .term      (pre_term)
    );

    // timer increment and overflow
    logic        tmr_inc;
    logic        ovf;
    assign tmr_inc = (psa_wdt ? src_tick : pre_term) & ~sleep_mode
                     & (inh_q == 2'h0) & ~wr_cnt;
    assign ovf     = tmr_inc & (cnt_q == 8'hff);

    // a count write beats a coincident increment, then holds it off
    // the two lost increments are the price of a simple load path;
    // software makes up for them by writing an adjusted value
    assign cnt_d = wr_cnt  ? hwdata[7:0] :
                   tmr_inc ? 8'(cnt_q + 8'h01) : cnt_q;
    assign inh_d = wr_cnt ? TMC_INHIBIT_CYC :
                   (inh_q != 2'h0) ? 2'(inh_q - 2'h1) : 2'h0;

    // interrupt control next value; an overflow wins over any clear
    // event enable and clear act on the control bits themselves, no copies
    always_comb begin
        icr_d = icr_q;
        if (wr_icr) begin
            icr_d = hwdata[7:0];
        end
        if (wr_even) begin
            icr_d[TMC_ICR_IE] = hwdata[TMC_EV_OVF];
        end
        if (wr_evclr && hwdata[TMC_EV_OVF]) begin
            icr_d[TMC_ICR_FLAG] = 1'b0;
        end
        if (ovf) begin
            icr_d[TMC_ICR_FLAG] = 1'b1;
        end
    end

    // bus slave: writes take no wait, reads one wait state so that
    // a read right behind a write sees the new value
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 12'h000;
            ready_q   <= 1'b1;
            rdata_q   <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_take;
            rd_pend_q <= rd_take;
            ready_q   <= ~rd_take;
            if (addr_ok) begin
                addr_q <= haddr[11:0];
            end
            if (rd_pend_q) begin
                rdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    // counter, inhibit and control registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= TMC_RST_COUNT;
            inh_q <= 2'h0;
            icr_q <= TMC_RST_ICTRL;
            opt_q <= TMC_RST_OPTION;
        end else begin
            cnt_q <= cnt_d;
            inh_q <= inh_d;
            icr_q <= icr_d;
            if (wr_opt) begin
                opt_q <= hwdata[7:0];
            end
        end
    end

    // two flip-flops before the pin is looked at, a third for edges
    // pulses narrower than one clock may be missed entirely
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_last_q <= 1'b0;
        end else begin
            pin_meta_q <= counter_clock_pin;
            pin_sync_q <= pin_meta_q;
            pin_last_q <= pin_sync_q;
        end
    end

    // registered outputs: masked interrupt and watchdog tick
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
            wdt_q <= 1'b0;
        end else begin
            irq_q <= icr_q[TMC_ICR_FLAG] & icr_q[TMC_ICR_IE];
            wdt_q <= psa_wdt ? pre_term : wdt_clk_tick;
        end
    end

    assign hreadyout = ready_q;
    assign hrdata    = rdata_q;
    assign hresp     = 1'b0;
    assign irq       = irq_q;
    assign wdt_tick  = wdt_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_timer_per_cycle: assert property (
        (!sel_pin && psa_wdt && !sleep_mode && inh_q == 2'h0 && !wr_cnt)
        |=> cnt_q == 8'($past(cnt_q) + 8'h01))
        else $error("timer mode missed an instruction cycle");

    a_write_inhibit: assert property (
        (wr_cnt ##1 !wr_cnt)
        |=> $stable(cnt_q) ##1 ($past(wr_cnt) || $stable(cnt_q)))
        else $error("count moved within two cycles of a write");

    a_write_loads: assert property (
        wr_cnt |=> cnt_q == $past(hwdata[7:0]) && inh_q == 2'h2)
        else $error("count write not loaded");

    a_pin_rise_count: assert property (
        (sel_pin && !sel_fall && psa_wdt && pin_rise && !sleep_mode
         && inh_q == 2'h0 && !wr_cnt) |=> cnt_q == 8'($past(cnt_q) + 8'h01))
        else $error("rising pin edge not counted");

    a_pin_fall_only: assert property (
        (sel_pin && sel_fall && psa_wdt && !pin_fall && !wr_cnt)
        |=> $stable(cnt_q))
        else $error("counted without a falling pin edge");

    a_watchdog_bypass: assert property (
        !psa_wdt |=> wdt_q == $past(wdt_clk_tick))
        else $error("watchdog tick divided while prescaler is the timer's");

    a_unmapped_zero: assert property (
        (rd_pend_q && addr_q != TMC_ADDR_COUNT && addr_q != TMC_ADDR_ICTRL
         && addr_q != TMC_ADDR_OPTION && addr_q != TMC_ADDR_EVSTAT
         && addr_q != TMC_ADDR_EVEN) |=> rdata_q == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_overflow_wrap: assert property (
        ovf |=> cnt_q == 8'h00 ##0 icr_q[TMC_ICR_FLAG])
        else $error("overflow did not wrap and flag");

    a_flag_sticky: assert property (
        (icr_q[TMC_ICR_FLAG] && !wr_icr && !wr_evclr)
        |=> icr_q[TMC_ICR_FLAG])
        else $error("overflow flag dropped without software");

    a_irq_masked: assert property (
        !icr_q[TMC_ICR_IE] |=> !irq_q)
        else $error("interrupt forwarded while masked");

    a_sleep_frozen: assert property (
        (sleep_mode && !wr_cnt && !wr_icr)
        |=> $stable(cnt_q) && !$rose(icr_q[TMC_ICR_FLAG]))
        else $error("counter moved during sleep");

    a_prescaled_rate: assert property (
        (!psa_wdt && !sel_pin && !sleep_mode && rate == 3'h0
         && inh_q == 2'h0 && !wr_cnt && !$past(wr_cnt) && tmr_inc)
        |=> !tmr_inc)
        else $error("prescaled timer advanced on consecutive cycles");

    // pin mode counts only selected edges; falling edge path
    a_pin_fall_count: assert property (
        (sel_pin && sel_fall && psa_wdt && pin_fall && !sleep_mode
         && inh_q == 2'h0 && !wr_cnt) |=> cnt_q == 8'($past(cnt_q) + 8'h01))
        else $error("falling pin edge not counted");

    a_pin_no_cycle: assert property (
        (sel_pin && psa_wdt && !pin_edge && !wr_cnt) |=> $stable(cnt_q))
        else $error("pin mode counted an instruction cycle");

    // with the prescaler on the watchdog the timer sees every tick
    a_bypass_tick: assert property (
        (psa_wdt && !sel_pin && !sleep_mode && inh_q == 2'h0 && !wr_cnt)
        |-> tmr_inc)
        else $error("timer divided while prescaler is the watchdog's");

    a_prescaled_step: assert property (
        (!psa_wdt && pre_term && !sleep_mode && inh_q == 2'h0 && !wr_cnt)
        |=> cnt_q == 8'($past(cnt_q) + 8'h01))
        else $error("prescaler terminal count not counted");

    // reads show one register byte, one wait state, upper bits zero
    a_read_wait: assert property (
        rd_take |=> !ready_q ##1 (ready_q && rdata_q[31:8] == 24'h00_0000))
        else $error("read wait state or upper data bits wrong");

    // the flag only rises on an overflow or a software write
    a_flag_cause: assert property (
        $rose(icr_q[TMC_ICR_FLAG]) |-> $past(ovf || wr_icr))
        else $error("overflow flag set without a cause");

    a_status_alias: assert property (
        (rd_pend_q && addr_q == TMC_ADDR_EVSTAT)
        |=> rdata_q == {31'h0, $past(icr_q[TMC_ICR_FLAG])})
        else $error("event status does not mirror the flag");

    a_irq_follows: assert property (
        (icr_q[TMC_ICR_FLAG] && icr_q[TMC_ICR_IE]) |=> irq_q)
        else $error("enabled overflow not forwarded");

    // hardware never clears the flag; only the two write paths do
    a_flag_no_self_clear: assert property (
        $fell(icr_q[TMC_ICR_FLAG]) |-> $past(wr_icr || wr_evclr))
        else $error("overflow flag cleared by hardware");

    a_sleep_no_ovf: assert property (
        sleep_mode |-> !ovf)
        else $error("overflow while asleep");

endmodule // tmc_timer

// *** verification/testbench.sv ***
// self-checking bench for the timer/counter behind its ahb-lite slave
// assumes tmc_pkg, tmc_timer and the pin source model are compiled first
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import tmc_pkg::*;

    logic        sys_clk, arst_n, hsel, hwrite, hreadyout, hresp;
    logic        pin, sleep_mode, wdt_clk_tick, wdt_tick, irq;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          err_count, compares, seed, v, n, k;
    int          exp_q[$];
    int          opt_tab[3] = '{8'h00, 8'h08, 8'h0a};
    int          div_tab[3] = '{1, 1, 4};

    tmc_timer dut_u (
        .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .counter_clock_pin(pin), .sleep_mode(sleep_mode),
        .wdt_clk_tick(wdt_clk_tick), .wdt_tick(wdt_tick), .irq(irq)
    );
    tmc_pin_source src_u (.pin(pin));

    // free-running 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one single ahb-lite transfer; waits on hready, never on a count
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= {20'h00000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic rdchk(input logic [11:0] a, input int exp);
        bus(1'b0, a, 32'h0);
        chk(rd, 32'(exp));
    endtask

    // wake for exactly n edges; the idle gap first lets a write inhibit end
    task automatic run(input int cyc);
        repeat (3) @(posedge sys_clk);
        sleep_mode <= 1'b0;
        repeat (cyc) @(posedge sys_clk);
        sleep_mode <= 1'b1;
    endtask

    // hang guard: the whole sequence needs well under 10k cycles
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        seed = 33952;
        {err_count, compares} = '0;
        {arst_n, hsel, hwrite, wdt_clk_tick} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        sleep_mode = 1'b1;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        // reset values, then an unmapped place that must ignore writes
        rdchk(TMC_ADDR_COUNT, TMC_RST_COUNT);
        rdchk(TMC_ADDR_ICTRL, TMC_RST_ICTRL);
        rdchk(TMC_ADDR_OPTION, TMC_RST_OPTION);
        bus(1'b1, 12'h0f0, 32'hffffffff);
        rdchk(12'h0f0, 0);
        // timer mode, no prescaler: random loads and wake spans
        bus(1'b1, TMC_ADDR_OPTION, 32'h08);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed) & 8'hff;
            n = ($random(seed) & 15) + 1;
            bus(1'b1, TMC_ADDR_COUNT, 32'(v));
            exp_q.push_back((v + n) & 255);
            run(n);
            rdchk(TMC_ADDR_COUNT, exp_q.pop_front());
        end
        // write while running: six edges give only four increments
        sleep_mode <= 1'b0;
        bus(1'b1, TMC_ADDR_COUNT, 32'h40);
        repeat (6) @(posedge sys_clk);
        sleep_mode <= 1'b1;
        rdchk(TMC_ADDR_COUNT, 8'h44);
        // prescaler on the timer, ratio two to the rate plus one
        for (int r = 0; r < 3; r++) begin
            v = $random(seed) & 8'hff;
            bus(1'b1, TMC_ADDR_OPTION, 32'(r));
            bus(1'b1, TMC_ADDR_COUNT, 32'(v));
            run(3 << (r + 1));
            rdchk(TMC_ADDR_COUNT, (v + 3) & 255);
        end
        // watchdog ticks: unscaled unless the prescaler is assigned there
        for (int j = 0; j < 3; j++) begin
            bus(1'b1, TMC_ADDR_OPTION, 32'(opt_tab[j]));
            wdt_clk_tick <= 1'b1;
            k = 0;
            for (int c = 0; c < 20; c++) begin
                @(posedge sys_clk);
                k += (wdt_tick === 1'b1);
                if (c == 15) wdt_clk_tick <= 1'b0;
            end
            chk(32'(k), 32'(16 / div_tab[j]));
        end
        // counter mode on both edges, with a quick and a slow source
        sleep_mode <= 1'b0;
        for (int se = 0; se < 2; se++) begin
            bus(1'b1, TMC_ADDR_OPTION, 32'(8'h28 | (se << 4)));
            bus(1'b1, TMC_ADDR_COUNT, 32'h10);
            src_u.burst(5, 17 + 24 * se);
            repeat (8) @(posedge sys_clk);
            rdchk(TMC_ADDR_COUNT, 8'h16 - se);
            src_u.idle(17);
        end
        sleep_mode <= 1'b1;
        // overflow, flag, mask, enable alias and clear
        bus(1'b1, TMC_ADDR_ICTRL, 32'h20);
        bus(1'b1, TMC_ADDR_OPTION, 32'h08);
        bus(1'b1, TMC_ADDR_COUNT, 32'hfe);
        run(3);
        rdchk(TMC_ADDR_COUNT, 8'h01);
        repeat (20) @(posedge sys_clk);
        rdchk(TMC_ADDR_ICTRL, 8'h24);
        rdchk(TMC_ADDR_EVSTAT, 1);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, TMC_ADDR_ICTRL, 32'h04);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, TMC_ADDR_EVEN, 32'h1);
        rdchk(TMC_ADDR_ICTRL, 8'h24);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, TMC_ADDR_EVCLR, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        rdchk(TMC_ADDR_ICTRL, 8'h20);
        tally_and_finish();
    end
endmodule // testbench

// *** verification/tmc_pin_source.sv ***
// partner model: the external clock source on the count pin
// assumes the bench calls burst from its own thread; pin idles low
module tmc_pin_source (
    output logic pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // the source is quiet until its first burst, so the line starts parked low
    initial pin = 1'b0;

    // n full pulses then a last rise; half period h ns, off the sys_clk grid
    task automatic burst(input int n, input int h);
        // half-step offset keeps every pin change off the rising sys_clk edges
        #0.5;
        repeat (n) begin
            #(h) pin = 1'b1;
            #(h) pin = 1'b0;
        end
        #(h) pin = 1'b1;
    endtask

    // return to idle; a falling edge the bench must allow for
    task automatic idle(input int h);
        #0.5;
        #(h) pin = 1'b0;
    endtask
endmodule // tmc_pin_source
